// file: aap_defs.vh
/*
 * Constants of the auto-negotiation advertisement and partner register pair:
 * register indices, field positions and reset values.
 * Assumes it is included by bare name from the design files.
 */
`ifndef AAP_DEFS_VH
`define AAP_DEFS_VH

// Register indices; byte address is four times the index.
`define AAP_IDX_CTRL      3'h0
`define AAP_IDX_STAT      3'h1
`define AAP_IDX_LAR       3'h4
`define AAP_IDX_PAR       3'h5

// Control register fields.
`define AAP_CTRL_SRST     15
`define AAP_CTRL_RESTART  9

// Status register fields.
`define AAP_STAT_LINK     2
`define AAP_STAT_PAGE     1

// Local advertisement field positions.
`define AAP_LAR_TOP_HI    15
`define AAP_LAR_TOP_LO    14
`define AAP_LAR_RF        13
`define AAP_LAR_B12       12
`define AAP_LAR_PAUSE_HI  11
`define AAP_LAR_PAUSE_LO  10
`define AAP_LAR_B9        9
`define AAP_LAR_ABIL_HI   8
`define AAP_LAR_ABIL_LO   5
`define AAP_SEL_HI        4
`define AAP_SEL_LO        0

// Partner ability field positions.
`define AAP_PAR_NP        15
`define AAP_PAR_ACK       14
`define AAP_PAR_RF        13
`define AAP_PAR_PAUSE_HI  11
`define AAP_PAR_PAUSE_LO  10

// Reset values.
`define AAP_TOP_RST       2'h2
`define AAP_PAUSE_RST     2'h0
`define AAP_ABIL_RST      4'hf
`define AAP_SEL_VAL       5'h01
`define AAP_PAR_RST       10'h000

`endif

// file: aap_edge.v
/*
 * Registered edge detector for a synchronous level.
 * Assumes the input is already synchronous to pclk.
 */
`timescale 1ns/100ps

module aap_edge #(
  parameter FALL = 0
) (
  // Clock and reset.
  input  wire pclk,
  input  wire presetn,
  // Level in, one-cycle pulse out.
  input  wire lvl,
  output reg  pulse_r
);

  reg prev_r;

  // The reset level of prev is low, so with FALL at 0 a high level at release is an edge.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r  <= 1'b0;
      pulse_r <= 1'b0;
    end else begin
      prev_r  <= lvl;
      pulse_r <= (FALL != 0) ? (prev_r & ~lvl) : (~prev_r & lvl);
    end
  end

endmodule // aap_edge

// file: aap_field.v
/*
 * One register field with a hardware reset value, an optional return to
 * that value on software reset, and a load port.
 * Assumes a single clock and an asynchronous active-low reset.
 */
`timescale 1ns/100ps

module aap_field #(
  parameter       W        = 1,
  parameter [W-1:0] RST    = {W{1'b0}},
  parameter       SOFT_CLR = 0
) (
  // Clock and reset.
  input  wire         pclk,
  input  wire         presetn,
  // Control.
  input  wire         soft_rst,
  input  wire         ld,
  input  wire [W-1:0] d,
  // Stored value.
  output reg  [W-1:0] q_r
);

  // Software reset wins over a load in the same cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= RST;
    end else if (soft_rst && (SOFT_CLR != 0)) begin
      q_r <= RST;
    end else if (ld) begin
      q_r <= d;
    end
  end

endmodule // aap_field

// file: aap_peer.sv
/* Behavioural negotiation engine on the far side of the register bank.
   Assumes the bench calls its tasks from one process, one at a time. */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
module aap_peer (
  // Clock and reset.
  input  wire        pclk,
  input  wire        presetn,
  // Link state and received pages toward the bank.
  output reg         link_up,
  output reg         page_rx_valid,
  output reg  [15:0] page_rx_data,
  // Active page and restart from the bank.
  input  wire [15:0] adv_page_r,
  input  wire        an_restart_r,
  // Page last put on the wire.
  output reg  [15:0] sent_r
);
  // Link starts up, so reset release gives no spurious link loss.
  initial begin
    link_up = 1'b1;
    page_rx_valid = 1'b0;
    page_rx_data = 16'h0000;
  end
  // A restart sends whatever page is active at that moment.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) sent_r <= 16'h0000;
    else if (an_restart_r) sent_r <= adv_page_r;
  end
  // Data shows garbage once valid drops, so a stale page cannot pass.
  task send_page(input [15:0] p);
    @(posedge pclk);
    page_rx_valid <= 1'b1;
    page_rx_data <= p;
    @(posedge pclk);
    page_rx_valid <= 1'b0;
    page_rx_data <= ~p;
  endtask
  task set_link(input v);
    @(posedge pclk);
    link_up <= v;
  endtask
endmodule // aap_peer

// file: aap_regs.v
/*
 * Auto-negotiation advertisement and link-partner ability registers with an
 * APB slave, a small control and status register, and the active page that
 * the negotiation engine sends.
 * Assumes the negotiation engine supplies received base pages and link
 * state synchronous to pclk, and picks up adv_page_r on an_restart_r.
 */
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
`include "aap_defs.vh"

module aap_regs (
  // Clock and reset.
  input  wire        pclk,
  input  wire        presetn,
  // APB slave.
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Negotiation engine side.
  input  wire        link_up,
  input  wire        page_rx_valid,
  input  wire [15:0] page_rx_data,
  output reg  [15:0] adv_page_r,
  output reg         an_restart_r,
  output reg         soft_rst_r
);

  ////////////////////////////////////////////////////////////////////////////
  // APB decode.

  wire       acc_phase;
  wire       wr_fire;
  wire       rd_fire;
  wire       mapped;
  wire [2:0] idx;
  reg        pready_nxt;

  assign idx       = paddr[4:2];
  assign acc_phase = psel & penable;
  // Writes take effect only at the edge where pready is high; reads are captured at the edge before.
  assign wr_fire   = acc_phase & pready & pwrite;
  assign rd_fire   = acc_phase & ~pready & ~pwrite;
  assign mapped    = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0) &&
                     ((idx == `AAP_IDX_CTRL) || (idx == `AAP_IDX_STAT) ||
                      (idx == `AAP_IDX_LAR)  || (idx == `AAP_IDX_PAR));

  // One wait state: pready rises in the second access cycle and drops
  // right after, so a back-to-back transfer always starts clean.
  always @* begin
    pready_nxt = acc_phase & ~pready;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= pready_nxt;
      pslverr <= pready_nxt & ~mapped;
    end
  end

  wire wr_ctrl;
  wire wr_lar;

  assign wr_ctrl = wr_fire & mapped & (idx == `AAP_IDX_CTRL);
  assign wr_lar  = wr_fire & mapped & (idx == `AAP_IDX_LAR);

  ////////////////////////////////////////////////////////////////////////////
  // Control commands.

  // Both command bits are pulses, so they read back as zero once taken.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= wr_ctrl & pwdata[`AAP_CTRL_SRST];
    end
  end

  reg restart_req_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart_req_r <= 1'b0;
    end else begin
      restart_req_r <= wr_ctrl & pwdata[`AAP_CTRL_RESTART];
    end
  end

  // Link loss restarts negotiation too, but only for some fields.
  wire link_loss;

  aap_edge #(
    .FALL (1)
  ) u_link_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .lvl     (link_up),
    .pulse_r (link_loss)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Local advertisement fields.

  wire [1:0] lar_top;
  wire       lar_rf;
  wire       lar_b12;
  wire [1:0] lar_pause;
  wire       lar_b9;
  wire [3:0] lar_abil;

  // Top bits return to 10 on either reset; software must write them back
  // unchanged, the block stores whatever it is given.
  aap_field #(
    .W        (2),
    .RST      (`AAP_TOP_RST),
    .SOFT_CLR (1)
  ) u_lar_top (
    .pclk     (pclk),
    .presetn  (presetn),
    .soft_rst (soft_rst_r),
    .ld       (wr_lar),
    .d        (pwdata[`AAP_LAR_TOP_HI:`AAP_LAR_TOP_LO]),
    .q_r      (lar_top)
  );

  aap_field #(
    .W        (1),
    .RST      (1'b0),
    .SOFT_CLR (0)
  ) u_lar_rf (
    .pclk     (pclk),
    .presetn  (presetn),
    .soft_rst (soft_rst_r),
    .ld       (wr_lar),
    .d        (pwdata[`AAP_LAR_RF]),
    .q_r      (lar_rf)
  );

  aap_field #(
    .W        (1),
    .RST      (1'b0),
    .SOFT_CLR (0)
  ) u_lar_b12 (
    .pclk     (pclk),
    .presetn  (presetn),
    .soft_rst (soft_rst_r),
    .ld       (wr_lar),
    .d        (pwdata[`AAP_LAR_B12]),
    .q_r      (lar_b12)
  );

  aap_field #(
    .W        (2),
    .RST      (`AAP_PAUSE_RST),
    .SOFT_CLR (0)
  ) u_lar_pause (
    .pclk     (pclk),
    .presetn  (presetn),
    .soft_rst (soft_rst_r),
    .ld       (wr_lar),
    .d        (pwdata[`AAP_LAR_PAUSE_HI:`AAP_LAR_PAUSE_LO]),
    .q_r      (lar_pause)
  );

  aap_field #(
    .W        (1),
    .RST      (1'b0),
    .SOFT_CLR (1)
  ) u_lar_b9 (
    .pclk     (pclk),
    .presetn  (presetn),
    .soft_rst (soft_rst_r),
    .ld       (wr_lar),
    .d        (pwdata[`AAP_LAR_B9]),
    .q_r      (lar_b9)
  );

  // The reset value of the ability bits is fixed by the model variant.
  aap_field #(
    .W        (4),
    .RST      (`AAP_ABIL_RST),
    .SOFT_CLR (0)
  ) u_lar_abil (
    .pclk     (pclk),
    .presetn  (presetn),
    .soft_rst (soft_rst_r),
    .ld       (wr_lar),
    .d        (pwdata[`AAP_LAR_ABIL_HI:`AAP_LAR_ABIL_LO]),
    .q_r      (lar_abil)
  );

  wire [15:0] lar_val;

  // The selector is a constant; writes to it are dropped.
  assign lar_val = {lar_top, lar_rf, lar_b12, lar_pause, lar_b9, lar_abil,
                    `AAP_SEL_VAL};

  ////////////////////////////////////////////////////////////////////////////
  // Active page and restart.

  wire restart_any;

  // A software reset also restarts negotiation with the retained fields.
  assign restart_any = restart_req_r | soft_rst_r;

  wire [15:0] lar_soft_val;

  // A software reset returns the top bits to 10 and bit 9 to 0 on the same
  // edge that reloads the page, so the page is built from those values
  // and not from the stale register contents.
  assign lar_soft_val = {`AAP_TOP_RST, lar_rf, lar_b12, lar_pause, 1'b0,
                         lar_abil, `AAP_SEL_VAL};

  // Written values sit in the register until negotiation restarts. A link
  // loss refreshes only remote fault and pause; ability changes wait for
  // an explicit restart so the partner never sees a half-updated page.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adv_page_r <= {`AAP_TOP_RST, 1'b0, 1'b0, `AAP_PAUSE_RST, 1'b0,
                     `AAP_ABIL_RST, `AAP_SEL_VAL};
    end else if (restart_any) begin
      // Field reset and page load share an edge; take the reset view.
      if (soft_rst_r) begin
        adv_page_r <= lar_soft_val;
      end else begin
        adv_page_r <= lar_val;
      end
    end else if (link_loss) begin
      adv_page_r[`AAP_LAR_RF] <= lar_rf;
      adv_page_r[`AAP_LAR_PAUSE_HI:`AAP_LAR_PAUSE_LO] <= lar_pause;
    end
  end

  // One-cycle strobe to the negotiation engine.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      an_restart_r <= 1'b0;
    end else begin
      an_restart_r <= restart_any | link_loss;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Partner ability fields.

  wire [9:0] par_q;
  wire [9:0] par_d;

  // Only the engine loads this register; the APB write path never
  // reaches it, so software writes are accepted and ignored.
  assign par_d = {page_rx_data[`AAP_PAR_NP],
                  page_rx_data[`AAP_PAR_ACK],
                  page_rx_data[`AAP_PAR_RF],
                  page_rx_data[`AAP_PAR_PAUSE_HI:`AAP_PAR_PAUSE_LO],
                  page_rx_data[`AAP_SEL_HI:`AAP_SEL_LO]};

  aap_field #(
    .W        (10),
    .RST      (`AAP_PAR_RST),
    .SOFT_CLR (1)
  ) u_par (
    .pclk     (pclk),
    .presetn  (presetn),
    .soft_rst (soft_rst_r),
    .ld       (page_rx_valid),
    .d        (par_d),
    .q_r      (par_q)
  );

  wire [15:0] par_val;

  // Unused partner bits read as zero.
  assign par_val = {par_q[9],
                    par_q[8],
                    par_q[7],
                    1'b0,
                    par_q[6:5],
                    5'h00,
                    par_q[4:0]};

  // Page seen since the last restart command or software reset, not cleared by link loss; a new page wins over the restart.
  reg page_seen_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_seen_r <= 1'b0;
    end else if (page_rx_valid) begin
      page_seen_r <= 1'b1;
    end else if (restart_any) begin
      page_seen_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data.

  reg [15:0] rd_val;

  always @* begin
    rd_val = 16'h0000;
    case (idx)
      `AAP_IDX_STAT: begin
        rd_val[`AAP_STAT_LINK] = link_up;
        rd_val[`AAP_STAT_PAGE] = page_seen_r;
      end
      `AAP_IDX_LAR: begin
        rd_val = lar_val;
      end
      `AAP_IDX_PAR: begin
        rd_val = par_val;
      end
      default: begin
        rd_val = 16'h0000;
      end
    endcase
  end

  // Read data is captured one cycle before pready and held until the
  // next read, so it is stable in the cycle the master samples it.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_fire) begin
      prdata <= mapped ? {16'h0000, rd_val} : 32'h00000000;
    end
  end

endmodule // aap_regs

// file: aap_regs_props.sv
/* Port checker for the register bank.
   Assumes a master that holds each request until pready. */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
module aap_regs_props (
  // Clock and reset.
  input wire        pclk,
  input wire        presetn,
  // APB.
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Engine side.
  input wire        link_up,
  input wire        page_rx_valid,
  input wire [15:0] page_rx_data,
  input wire [15:0] adv_page_r,
  input wire        an_restart_r,
  input wire        soft_rst_r
);
  // Accepted control write; the request is still held on this edge.
  wire cw = psel && penable && pready && pwrite && paddr == 8'h00;
  wire hit = paddr == 8'h00 || paddr == 8'h04 ||
             paddr == 8'h10 || paddr == 8'h14;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_wait: assert property ($rose(psel && penable) |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_err_unmapped: assert property (pready |-> pslverr == !hit)
    else $error("pslverr wrong");
  a_sel_active: assert property (adv_page_r[4:0] == 5'h01)
    else $error("active selector wrong");
  a_sel_read: assert property (pready && !pwrite && paddr == 8'h10 |->
    prdata[4:0] == 5'h01) else $error("read selector wrong");
  a_adv_on_restart: assert property (!$stable(adv_page_r) |->
    an_restart_r) else $error("page changed without restart");
  a_restart_delay: assert property (cw && pwdata[9] |->
    ##[2:3] an_restart_r) else $error("no restart pulse");
  a_soft_seq: assert property (cw && pwdata[15] |->
    ##[1:2] (soft_rst_r ##1 an_restart_r)) else $error("soft reset seq");
  a_link_loss: assert property ($fell(link_up) |->
    ##[1:3] an_restart_r) else $error("no restart on link loss");
  cover property (cw && pwdata[9]);
  cover property (pready && pslverr);
  cover property ($fell(link_up));
endmodule // aap_regs_props
bind aap_regs aap_regs_props i_props (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link_up,
  .page_rx_valid, .page_rx_data, .adv_page_r, .an_restart_r, .soft_rst_r);

// file: testbench.sv
/* Self-checking bench for the register bank.
   Assumes the engine model aap_peer and the bound port checker. */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
module testbench;
  reg         pclk, presetn, psel, penable, pwrite, rerr;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire        pready, pslverr, link_up, page_rx_valid;
  wire        an_restart_r, soft_rst_r;
  wire [15:0] page_rx_data, adv_page_r, sent;
  integer     err_count, checks_done, cyc, i;
  localparam [7:0] CT = 8'h00, ST = 8'h04, LA = 8'h10, PA = 8'h14;
  aap_regs i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .link_up, .page_rx_valid,
    .page_rx_data, .adv_page_r, .an_restart_r, .soft_rst_r);
  aap_peer i_peer (.pclk, .presetn, .link_up, .page_rx_valid,
    .page_rx_data, .adv_page_r, .an_restart_r, .sent_r(sent));
  // Free-running clock, 20 ns.
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // A hang is cut short well past the 125 or so cycles needed.
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      err_count = err_count + 1;
      wrap_up;
    end
  end
  task wrap_up;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done = checks_done + 1;
    if (e !== g) begin
      err_count = err_count + 1;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  // Setup, access until pready, then release; no fixed latency assumed.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e, input string n,
           input logic [31:0] m = 32'hffffffff);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd & m);
  endtask
  // Main sequence.
  initial begin
    {err_count, checks_done, cyc} = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(LA, 32'h81e1, "lar reset");
    rdc(PA, 32'h0, "par reset");
    chk("adv reset", 32'h81e1, {16'h0, adv_page_r});
    for (i = 0; i < 4; i = i + 1) begin
      apb(1'b1, LA, 32'h8001 | (i << 10));
      rdc(LA, 32'h8001 | (i << 10), "pause");
    end
    apb(1'b1, LA, 32'hac1f);
    rdc(LA, 32'hac01, "lar sel");
    chk("adv held", 32'h81e1, {16'h0, adv_page_r});
    apb(1'b1, CT, 32'h0200);
    repeat (4) @(posedge pclk);
    chk("adv restart", 32'hac01, {16'h0, adv_page_r});
    chk("sent", 32'hac01, {16'h0, sent});
    rdc(CT, 32'h0, "ctrl sc", 32'h8200);
    apb(1'b1, LA, 32'ha6a1);
    i_peer.set_link(1'b0);
    repeat (4) @(posedge pclk);
    chk("adv link", 32'ha401, {16'h0, adv_page_r});
    rdc(LA, 32'ha6a1, "lar b9");
    i_peer.set_link(1'b1);
    i_peer.send_page(16'hfc15);
    rdc(PA, 32'hec15, "par page");
    apb(1'b1, PA, 32'h0);
    rdc(PA, 32'hec15, "par ro");
    rdc(ST, 32'h6, "stat page");
    apb(1'b1, CT, 32'h8000);
    repeat (4) @(posedge pclk);
    rdc(LA, 32'ha4a1, "lar soft");
    rdc(PA, 32'h0, "par soft");
    chk("adv soft", 32'ha4a1, {16'h0, adv_page_r});
    rdc(ST, 32'h4, "stat clr");
    // Hardware reset in mid-run clears what software reset kept.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(LA, 32'h81e1, "lar hw");
    chk("adv hw", 32'h81e1, {16'h0, adv_page_r});
    chk("sent hw", 32'h0, {16'h0, sent});
    rdc(8'h08, 32'h0, "unmapped");
    chk("slverr", 32'h1, {31'h0, rerr});
    wrap_up;
  end
endmodule // testbench
